// [pcpr_regs.vh]
`ifndef PCPR_REGS_VH
`define PCPR_REGS_VH

// byte offsets of the capability words
`define PCPR_OFF_HDR 8'hc0
`define PCPR_OFF_DEVCAP 8'hc4
`define PCPR_OFF_DEVCTL 8'hc8
`define PCPR_OFF_LNKCAP 8'hcc

// capability header fields
`define PCPR_CAP_ID 8'h10
`define PCPR_NEXT_PTR 8'h00
`define PCPR_CAP_VER 4'h2
`define PCPR_TYPE_UP 4'h5
`define PCPR_TYPE_DN 4'h6
`define PCPR_SLOT_UP_RST 1'b0
`define PCPR_SLOT_DN_RST 1'b1
`define PCPR_INT_MSG_NUM 5'h00

// payload size encodings
`define PCPR_MPS_128 3'h0
`define PCPR_MPS_256 3'h1
`define PCPR_MPS_512 3'h2

// device capabilities fields
`define PCPR_PHANTOM_SUP 2'h0
`define PCPR_EXT_TAG_SUP 1'b0
`define PCPR_L0S_ACC_LAT 3'h0
`define PCPR_L1_ACC_LAT 3'h0
`define PCPR_RBER_RST 1'b1
`define PCPR_SPL_VAL_RST 8'h00
`define PCPR_SPL_SCL_RST 2'h0

// device control and status bit positions and fixed values
`define PCPR_CTL_MPS_LSB 5
`define PCPR_CTL_AUXPM_BIT 10
`define PCPR_STS_ERR_LSB 16
`define PCPR_MRRS 3'h0
`define PCPR_AUX_DET_RST 1'b1
`define PCPR_TRANS_PEND 1'b0

// link capabilities fields
`define PCPR_SPEED_2G5 4'h1
`define PCPR_SPEED_5G 4'h2
`define PCPR_WIDTH_X4 6'h04
`define PCPR_WIDTH_X1 6'h01
`define PCPR_ASPM_RST 2'h0
`define PCPR_L0S_EXIT_RST 3'h3
`define PCPR_L1_EXIT_RST 3'h0
`define PCPR_CLKPM_UP_RST 1'b1
`define PCPR_CLKPM_DN 1'b0

`endif

// [pcpr_port_caps.v]
// Functional notes
// - capability id 10h, next pointer 00h
// - capability version reads 2h
// - port type 0101b upstream, 0110b downstream
// - slot implemented by port, loader may replace
// - interrupt message number reads zero
// - supported payload from strap, 001b or 010b
// - phantom and extended tag support read zero
// - endpoint acceptable latencies read 000b
// - role based error reporting resets 1, loadable
// - upstream captures slot power limit message
// - four error reporting enables, read-write, reset 0
// - relaxed ordering and no snoop read 0
// - max payload write clamped to supported value
// - extended tag and phantom enables read 0
// - aux power pm enable read-write, reset 0
// - max read request size hardwired 000b
// - error detected bits sticky, write one clears
// - aux power detected resets 1, pending 0
// - max link speed resets to 5.0 Gb/s
// - link width x4 upstream wide, else x1
// - L0s exit 011b, ASPM 00b, loadable
// - L1 exit 000b; clock pm by port
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`include "pcpr_regs.vh"

module pcpr_port_caps #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // avalon-mm slave
  input wire [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  // straps, sampled once after reset release
  input wire UPSTREAM_PORT_I,
  input wire PAYLOAD_SIZE_STRAP_I,
  input wire WIDE_UPSTREAM_I,
  // sideband default loader
  input wire LOAD_VALID_I,
  input wire LOAD_SLOT_IMPL_I,
  input wire [2:0] LOAD_MPS_SUP_I,
  input wire LOAD_RBER_I,
  input wire [1:0] LOAD_ASPM_I,
  input wire [2:0] LOAD_L0S_EXIT_I,
  input wire [2:0] LOAD_L1_EXIT_I,
  input wire LOAD_CLKPM_I,
  // received slot power limit message
  input wire SPL_MSG_VALID_I,
  input wire [7:0] SPL_MSG_VALUE_I,
  input wire [1:0] SPL_MSG_SCALE_I,
  // detected error events, one cycle each, then aux power present level
  input wire ERR_COR_I,
  input wire ERR_NONFATAL_I,
  input wire ERR_FATAL_I,
  input wire ERR_UNSUP_REQ_I,
  input wire AUX_POWER_PRESENT_I,
  // control towards the port logic
  output wire [3:0] ERR_REPORT_EN_O,
  output wire [2:0] MAX_PAYLOAD_O,
  output wire AUX_PM_EN_O
);

  // word indices of the mapped registers; address bits 1:0 pick no lane
  localparam [7:0] off_hdr = `PCPR_OFF_HDR;
  localparam [7:0] off_devcap = `PCPR_OFF_DEVCAP;
  localparam [7:0] off_devctl = `PCPR_OFF_DEVCTL;
  localparam [7:0] off_lnkcap = `PCPR_OFF_LNKCAP;
  localparam [5:0] word_hdr = off_hdr[7:2];
  localparam [5:0] word_devcap = off_devcap[7:2];
  localparam [5:0] word_devctl = off_devctl[7:2];
  localparam [5:0] word_lnkcap = off_lnkcap[7:2];

  // bus handshake
  reg wait_ff;
  reg nxt_wait;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;

  // strap capture
  reg init_done_ff;
  reg upstream_ff;

  // strap and loadable defaults
  reg [3:0] port_type_ff;
  reg slot_impl_ff;
  reg [2:0] mps_sup_ff;
  reg rber_ff;
  reg [5:0] width_ff;
  reg [1:0] aspm_ff;
  reg [2:0] l0s_exit_ff;
  reg [2:0] l1_exit_ff;
  reg clkpm_ff;

  // captured slot power limit
  reg [7:0] spl_val_ff;
  reg [1:0] spl_scl_ff;

  // device control and status
  reg [3:0] err_en_ff;
  reg [3:0] nxt_err_en;
  reg [2:0] mps_ff;
  reg [2:0] nxt_mps;
  reg aux_pm_ff;
  reg nxt_aux_pm;
  reg aux_det_ff;

  wire [5:0] word_sel;
  wire do_write;
  wire sel_devctl;
  wire wr_lane_lo;
  wire wr_lane_aux;
  wire wr_lane_sts;
  wire [3:0] sts_clr;
  wire [3:0] err_sts;
  wire [3:0] err_evt;
  wire [31:0] hdr_word;
  wire [31:0] devcap_word;
  wire [31:0] devctl_word;
  wire [31:0] lnkcap_word;
  wire [2:0] wr_mps;

  assign word_sel = AVS_ADDRESS_I[7:2];
  // a write lands only on the edge where the master sees waitrequest low
  assign do_write = AVS_WRITE_I & ~wait_ff;
  assign err_evt = {ERR_UNSUP_REQ_I, ERR_FATAL_I, ERR_NONFATAL_I, ERR_COR_I};
  assign wr_mps = AVS_WRITEDATA_I[7:5];
  assign sel_devctl = (word_sel == word_devctl);
  assign wr_lane_lo = do_write & sel_devctl & AVS_BYTEENABLE_I[0];
  assign wr_lane_aux = do_write & sel_devctl & AVS_BYTEENABLE_I[1];
  assign wr_lane_sts = do_write & sel_devctl & AVS_BYTEENABLE_I[2];
  assign sts_clr = wr_lane_sts ?
                   AVS_WRITEDATA_I[`PCPR_STS_ERR_LSB+3:`PCPR_STS_ERR_LSB] : 4'h0;

  assign hdr_word = {2'h0,
                     `PCPR_INT_MSG_NUM,
                     slot_impl_ff,
                     port_type_ff,
                     `PCPR_CAP_VER,
                     `PCPR_NEXT_PTR,
                     `PCPR_CAP_ID};

  assign devcap_word = {4'h0,
                        spl_scl_ff,
                        spl_val_ff,
                        2'h0,
                        rber_ff,
                        3'h0,
                        `PCPR_L1_ACC_LAT,
                        `PCPR_L0S_ACC_LAT,
                        `PCPR_EXT_TAG_SUP,
                        `PCPR_PHANTOM_SUP,
                        mps_sup_ff};

  assign devctl_word = {10'h000,
                        `PCPR_TRANS_PEND,
                        aux_det_ff,
                        err_sts,
                        1'b0,
                        `PCPR_MRRS,
                        1'b0,
                        aux_pm_ff,
                        2'h0,
                        mps_ff,
                        1'b0,
                        err_en_ff};

  // bits above clock pm are outside this bank and read zero
  assign lnkcap_word = {13'h0000,
                        clkpm_ff,
                        l1_exit_ff,
                        l0s_exit_ff,
                        aspm_ff,
                        width_ff,
                        `PCPR_SPEED_5G};

  // one wait cycle, then one answer cycle; unmapped words read zero
  always @* begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    if ((AVS_READ_I | AVS_WRITE_I) & wait_ff) begin
      nxt_wait = 1'b0;
      nxt_rdata = 32'h00000000;
      if (AVS_READ_I) begin
        case (word_sel)
          word_hdr: nxt_rdata = hdr_word;
          word_devcap: nxt_rdata = devcap_word;
          word_devctl: nxt_rdata = devctl_word;
          word_lnkcap: nxt_rdata = lnkcap_word;
          default: nxt_rdata = 32'h00000000;
        endcase
      end
    end
  end

  // device control fields; read-only and reserved lanes take nothing
  always @* begin
    nxt_err_en = err_en_ff;
    nxt_mps = mps_ff;
    nxt_aux_pm = aux_pm_ff;
    if (wr_lane_lo) begin
      nxt_err_en = AVS_WRITEDATA_I[3:0];
      if (wr_mps > mps_sup_ff) begin
        nxt_mps = mps_sup_ff;
      end else begin
        nxt_mps = wr_mps;
      end
    end
    if (wr_lane_aux) begin
      nxt_aux_pm = AVS_WRITEDATA_I[`PCPR_CTL_AUXPM_BIT];
    end
    // a lowered supported size must not leave a larger setting behind
    if (nxt_mps > mps_sup_ff) begin
      nxt_mps = mps_sup_ff;
    end
  end

  // error detected flags log whatever the enables say
  pcpr_sticky_flag #(
    .RST_VAL(1'b0)
  ) u_sts_cor (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(err_evt[0]),
    .clr_i(sts_clr[0]),
    .flag_o(err_sts[0])
  );

  pcpr_sticky_flag #(
    .RST_VAL(1'b0)
  ) u_sts_nonfatal (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(err_evt[1]),
    .clr_i(sts_clr[1]),
    .flag_o(err_sts[1])
  );

  pcpr_sticky_flag #(
    .RST_VAL(1'b0)
  ) u_sts_fatal (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(err_evt[2]),
    .clr_i(sts_clr[2]),
    .flag_o(err_sts[2])
  );

  pcpr_sticky_flag #(
    .RST_VAL(1'b0)
  ) u_sts_unsup (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(err_evt[3]),
    .clr_i(sts_clr[3]),
    .flag_o(err_sts[3])
  );

  // bus answer registers
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // software-owned control fields
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      err_en_ff <= 4'h0;
      mps_ff <= `PCPR_MPS_128;
      aux_pm_ff <= 1'b0;
    end else begin
      err_en_ff <= nxt_err_en;
      mps_ff <= nxt_mps;
      aux_pm_ff <= nxt_aux_pm;
    end
  end

  // aux power status lags its input by one edge and skips the init edge
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aux_det_ff <= `PCPR_AUX_DET_RST;
    end else if (init_done_ff) begin
      aux_det_ff <= AUX_POWER_PRESENT_I;
    end
  end

  // straps are caught on the first edge after release, never under reset
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      init_done_ff <= 1'b0;
      upstream_ff <= 1'b1;
      port_type_ff <= `PCPR_TYPE_UP;
      slot_impl_ff <= `PCPR_SLOT_UP_RST;
      mps_sup_ff <= `PCPR_MPS_256;
      rber_ff <= `PCPR_RBER_RST;
      width_ff <= `PCPR_WIDTH_X1;
      aspm_ff <= `PCPR_ASPM_RST;
      l0s_exit_ff <= `PCPR_L0S_EXIT_RST;
      l1_exit_ff <= `PCPR_L1_EXIT_RST;
      clkpm_ff <= `PCPR_CLKPM_UP_RST;
    end else if (!init_done_ff) begin
      init_done_ff <= 1'b1;
      upstream_ff <= UPSTREAM_PORT_I;
      port_type_ff <= UPSTREAM_PORT_I ? `PCPR_TYPE_UP : `PCPR_TYPE_DN;
      slot_impl_ff <= UPSTREAM_PORT_I ? `PCPR_SLOT_UP_RST : `PCPR_SLOT_DN_RST;
      mps_sup_ff <= PAYLOAD_SIZE_STRAP_I ? `PCPR_MPS_512 : `PCPR_MPS_256;
      width_ff <= (UPSTREAM_PORT_I & WIDE_UPSTREAM_I) ? `PCPR_WIDTH_X4 : `PCPR_WIDTH_X1;
      clkpm_ff <= UPSTREAM_PORT_I ? `PCPR_CLKPM_UP_RST : `PCPR_CLKPM_DN;
    end else if (LOAD_VALID_I) begin
      slot_impl_ff <= LOAD_SLOT_IMPL_I;
      // only the three documented encodings are accepted
      if (LOAD_MPS_SUP_I <= `PCPR_MPS_512) begin
        mps_sup_ff <= LOAD_MPS_SUP_I;
      end
      rber_ff <= LOAD_RBER_I;
      aspm_ff <= LOAD_ASPM_I;
      l0s_exit_ff <= LOAD_L0S_EXIT_I;
      l1_exit_ff <= LOAD_L1_EXIT_I;
      clkpm_ff <= upstream_ff & LOAD_CLKPM_I;
    end
  end

  // slot power limit is meaningful only on the upstream port
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      spl_val_ff <= `PCPR_SPL_VAL_RST;
      spl_scl_ff <= `PCPR_SPL_SCL_RST;
    end else if (SPL_MSG_VALID_I && upstream_ff && init_done_ff) begin
      spl_val_ff <= SPL_MSG_VALUE_I;
      spl_scl_ff <= SPL_MSG_SCALE_I;
    end
  end

  assign AVS_READDATA_O = rdata_ff;
  assign AVS_WAITREQUEST_O = wait_ff;
  assign ERR_REPORT_EN_O = err_en_ff;
  assign MAX_PAYLOAD_O = mps_ff;
  assign AUX_PM_EN_O = aux_pm_ff;

endmodule

// one status flag: a hardware set beats a software clear in the same cycle
module pcpr_sticky_flag #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire set_i,
  input wire clr_i,
  output wire flag_o
);

  reg flag_ff;
  reg nxt_flag;

  always @* begin
    nxt_flag = flag_ff;
    if (clr_i) begin
      nxt_flag = 1'b0;
    end
    if (set_i) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;

endmodule

// [pcpr_port_caps_props.sv]
`timescale 1ns/100ps
module pcpr_port_caps_chk #(
  parameter ADDR_W = 8
) (
  // watched ports
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [3:0] ERR_REPORT_EN_O,
  input wire logic [2:0] MAX_PAYLOAD_O,
  input wire logic AUX_PM_EN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic ans = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire logic [5:0] wd = AVS_ADDRESS_I[7:2];
  wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  req_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("request not answered");
  hdr_fixed_a: assert property (ans && wd == 6'h30 |->
    AVS_READDATA_O[19:0] == 20'h20010 && AVS_READDATA_O[31:25] == 7'h0)
    else $error("header word wrong");
  cap_fixed_a: assert property (ans && wd == 6'h31 |-> AVS_READDATA_O[14:3] == 12'h0
    && AVS_READDATA_O[17:16] == 2'h0 && AVS_READDATA_O[31:28] == 4'h0)
    else $error("device caps fixed bits wrong");
  ctl_image_a: assert property (ans && wd == 6'h32 |->
    AVS_READDATA_O[3:0] == ERR_REPORT_EN_O && AVS_READDATA_O[7:5] == MAX_PAYLOAD_O
    && AVS_READDATA_O[10] == AUX_PM_EN_O && AVS_READDATA_O[15:11] == 5'h0
    && AVS_READDATA_O[9:8] == 2'h0 && AVS_READDATA_O[4] == 1'b0
    && AVS_READDATA_O[31:21] == 11'h0) else $error("control word wrong");
  lnk_fixed_a: assert property (ans && wd == 6'h33 |->
    AVS_READDATA_O[3:0] == 4'h2 && AVS_READDATA_O[31:19] == 13'h0)
    else $error("link caps fixed bits wrong");
  mps_clamp_a: assert property (MAX_PAYLOAD_O <= 3'h2)
    else $error("max payload above 512");
  enable_hold_a: assert property (!$stable({ERR_REPORT_EN_O, AUX_PM_EN_O}) |->
    $past(AVS_WRITE_I && !AVS_WAITREQUEST_O)) else $error("enable moved without write");
  cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  cover property (ans && wd == 6'h32 && AVS_READDATA_O[19:16] == 4'hf);
  cover property (ERR_REPORT_EN_O == 4'hf && AUX_PM_EN_O);
endmodule
bind pcpr_port_caps pcpr_port_caps_chk #(.ADDR_W(ADDR_W)) chk (.*);

// [pcpr_cfg_sw.sv]
`timescale 1ns/100ps
module pcpr_cfg_sw (
  // bus side
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  output logic [7:0] addr_o = 8'h00,
  output logic rd_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [31:0] wdata_o = 32'h0,
  output logic [3:0] be_o = 4'h0
);
  // one idle edge first so back-to-back calls keep the required spacing
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= d;
    be_o <= b;
    @(posedge clk_i);
    // no cycle limit here: a slave that never answers is caught by the bench watchdog
    while (wait_i !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic up = 1'b0, pl = 1'b0, wide = 1'b0, aux = 1'b1, spl_v = 1'b0;
  logic ld_v = 1'b0, ld_slot = 1'b0, ld_rber = 1'b0, ld_ck = 1'b0;
  logic [2:0] ld_mps = 3'h0, ld_l0s = 3'h0, ld_l1 = 3'h0, mps;
  logic [1:0] ld_aspm = 2'h0, spl_scl = 2'h0;
  logic [7:0] spl_val = 8'h00, addr;
  logic [3:0] err = 4'h0, be, en;
  logic [31:0] wdata, rdata, q;
  logic rd, wr, wt, auxen;
  int bad_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  pcpr_cfg_sw m (.clk_i(clk), .rdata_i(rdata), .wait_i(wt), .addr_o(addr), .rd_o(rd),
    .wr_o(wr), .wdata_o(wdata), .be_o(be));
  pcpr_port_caps #(.ADDR_W(8)) uut (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wt), .UPSTREAM_PORT_I(up),
    .PAYLOAD_SIZE_STRAP_I(pl), .WIDE_UPSTREAM_I(wide), .LOAD_VALID_I(ld_v),
    .LOAD_SLOT_IMPL_I(ld_slot), .LOAD_MPS_SUP_I(ld_mps), .LOAD_RBER_I(ld_rber),
    .LOAD_ASPM_I(ld_aspm), .LOAD_L0S_EXIT_I(ld_l0s), .LOAD_L1_EXIT_I(ld_l1),
    .LOAD_CLKPM_I(ld_ck), .SPL_MSG_VALID_I(spl_v), .SPL_MSG_VALUE_I(spl_val),
    .SPL_MSG_SCALE_I(spl_scl), .ERR_COR_I(err[0]), .ERR_NONFATAL_I(err[1]),
    .ERR_FATAL_I(err[2]), .ERR_UNSUP_REQ_I(err[3]), .AUX_POWER_PRESENT_I(aux),
    .ERR_REPORT_EN_O(en), .MAX_PAYLOAD_O(mps), .AUX_PM_EN_O(auxen));
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    m.xfer(1'b0, a, 32'h0, 4'hf, q);
    `CHK(n, e, q)
  endtask
  task automatic boot(input logic u, input logic p, input logic w);
    rst_n <= 1'b0;
    up <= u;
    pl <= p;
    wide <= w;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_defaults(input logic u, input logic p, input logic w);
    boot(u, p, w);
    rchk("hdr", 8'hc0, {7'h0, !u, u ? 4'h5 : 4'h6, 20'h20010});
    rchk("devcap", 8'hc4, {16'h0, 13'h1000, p ? 3'h2 : 3'h1});
    rchk("devctl", 8'hc8, 32'h0010_0000);
    rchk("lnkcap", 8'hcc, {13'h0, u, 6'h03, 2'h0, (u && w) ? 6'h4 : 6'h1, 4'h2});
    rchk("unmapped", 8'h40, 32'h0);
  endtask
  // all-ones write also probes the read-only and reserved bits
  task automatic t_ctl();
    m.xfer(1'b1, 8'hc0, 32'hffff_ffff, 4'hf, q);
    m.xfer(1'b1, 8'hc8, 32'hffff_ffff, 4'hf, q);
    rchk("ctl", 8'hc8, {16'h0010, 5'h0, 1'b1, 2'h0, pl ? 3'h2 : 3'h1, 5'h0f});
    `CHK("enables", 5'h1f, {auxen, en})
    `CHK("mps_out", pl ? 3'h2 : 3'h1, mps)
    rchk("hdr_ro", 8'hc0, {7'h0, !up, up ? 4'h5 : 4'h6, 20'h20010});
    m.xfer(1'b1, 8'hc8, 32'h0, 4'hf, q);
    rchk("ctl_clr", 8'hc8, 32'h0010_0000);
    `CHK("outs_clr", 8'h00, {auxen, en, mps})
  endtask
  // enables set on the low lanes must survive a status-only clear on lane 2
  task automatic t_err();
    m.xfer(1'b1, 8'hc8, 32'h0000_0405, 4'h3, q);
    err <= 4'hf;
    @(posedge clk);
    err <= 4'h0;
    rchk("sts_set", 8'hc8, 32'h001f_0405);
    m.xfer(1'b1, 8'hc8, 32'h0005_0000, 4'h4, q);
    rchk("sts_w1c", 8'hc8, 32'h001a_0405);
    `CHK("keep_en", 5'h15, {auxen, en})
  endtask
  task automatic t_spl();
    spl_val <= 8'ha5;
    spl_scl <= 2'h3;
    spl_v <= 1'b1;
    @(posedge clk);
    spl_v <= 1'b0;
    rchk("spl", 8'hc4, {4'h0, 2'h3, 8'ha5, 3'h1, 12'h0, pl ? 3'h2 : 3'h1});
  endtask
  // downstream: loader lowers payload, so a 512 write must clamp to 128
  task automatic t_load();
    boot(1'b0, 1'b1, 1'b0);
    {ld_slot, ld_mps, ld_rber, ld_aspm, ld_l0s, ld_l1, ld_ck} <= 14'h01dd;
    ld_v <= 1'b1;
    spl_v <= 1'b1;
    @(posedge clk);
    ld_v <= 1'b0;
    spl_v <= 1'b0;
    m.xfer(1'b1, 8'hc8, 32'h0000_0040, 4'hf, q);
    rchk("ctl_clamp", 8'hc8, 32'h0010_0000);
    `CHK("mps_ld", 3'h0, mps)
    rchk("hdr_ld", 8'hc0, 32'h0062_0010);
    rchk("cap_ld", 8'hc4, 32'h0);
    rchk("lnk_ld", 8'hcc, {13'h0, 1'b0, 3'h6, 3'h5, 2'h3, 6'h1, 4'h2});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    print_verdict();
  end
  initial begin
    t_defaults(1'b0, 1'b0, 1'b1);
    t_defaults(1'b1, 1'b1, 1'b1);
    t_defaults(1'b1, 1'b0, 1'b0);
    t_ctl();
    t_err();
    t_spl();
    t_load();
    print_verdict();
  end
endmodule
